// File: tb/ebrwc_peer.sv
// Purpose: External peripheral model answering bus cycles.
// Assumes: Strobe stays high for the whole cycle.
// Notes: Released data shows the inverse word, not a held value.
`timescale 1ns/1ps
module ebrwc_peer (
  input wire logic clock,
  input wire logic strobe,
  input wire logic active_high,
  input wire logic [7:0] delay,
  input wire logic [15:0] word,
  output logic ready_pin,
  output logic [15:0] data_pin
);
  logic [7:0] count = 8'h00;
  // Driven on the clock edge, so synchronous mode timing holds
  always @(posedge clock) begin
    count <= strobe ? count + 8'h01 : 8'h00;
    ready_pin <= (strobe && count >= delay) ? active_high : ~active_high;
    data_pin <= strobe ? word : ~word;
  end
endmodule : ebrwc_peer

// File: tb/external_bus_ready_wait_control_bench.sv
// Purpose: Self-checking bench for ready/wait control.
// Assumes: Cycle lengths counted in edges from the taking edge.
// Notes: Checks relative lengths where latency is a design choice.
`timescale 1ns/1ps
module external_bus_ready_wait_control_bench;
  import ebrwc_pkg::*;
  logic clock, rst_n, ready_active_high, ready_async, ready_pin, read_data_valid;
  logic [15:0] data_pin, read_data, word;
  logic [7:0] delay;
  logic ref_clock;
  ebrwc_req_t req;
  ebrwc_stat_t stat;
  int bad_count = 0;
  int compares = 0;
  ebrwc_ctrl DUT (.clock(clock), .rst_n(rst_n), .req(req), .ready_active_high(ready_active_high),
    .ready_async(ready_async), .ready_pin(ready_pin), .data_pin(data_pin), .stat(stat),
    .read_data(read_data), .read_data_valid(read_data_valid), .reference_clock_output(ref_clock));
  ebrwc_peer peer (.clock(clock), .strobe(stat.strobe), .active_high(ready_active_high),
    .delay(delay), .word(word), .ready_pin(ready_pin), .data_pin(data_pin));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  // Idle gap lets the ready pipeline drain before the next cycle
  task automatic run(input logic rd, input logic rc, input logic [3:0] n, input logic [7:0] d, output int len);
    logic wp;
    logic [15:0] prev;
    wp = 1'h0;
    repeat (4) @(posedge clock);
    prev = read_data;
    delay <= d;
    word <= word ^ 16'h5A3C;
    req <= '{1'h1, rd, rc, n};
    @(posedge clock);
    req.start <= 1'h0;
    len = 0;
    do begin
      @(posedge clock);
      if (len == 0) check("busy", {31'h0, stat.busy}, 32'h1);
      wp = wp | stat.ready_waitstate_phase;
      len++;
    end while (stat.done !== 1'h1 && len < 60);
    check("cycle_done", {31'h0, stat.done}, 32'h1);
    @(posedge clock);
    check("busy_after", {31'h0, stat.busy}, 32'h0);
    check("wait_phase", {31'h0, wp}, {31'h0, rc});
    check("read_valid", {31'h0, read_data_valid}, {31'h0, rd});
    check("read_data", {16'h0000, read_data}, {16'h0000, rd ? word : prev});
  endtask : run
  task automatic t_phases;
    int a, b, c;
    run(1'h1, 1'h0, 4'h1, 8'h00, a);
    run(1'h1, 1'h0, 4'h3, 8'h00, b);
    run(1'h0, 1'h0, 4'h0, 8'h00, c);
    check("first_sample", 32'(a), 32'h2);
    check("zero_phase", 32'(c), 32'h1);
    check("mand_phase_len", 32'(b - a), 32'h2);
  endtask : t_phases
  task automatic t_modes;
    int s0, s1, a;
    for (int ah = 0; ah < 2; ah++) begin
      ready_active_high <= ah[0];
      ready_async <= 1'b0;
      run(1'h1, 1'h1, 4'h1, 8'h00, s1);
      ready_async <= 1'h1;
      run(1'h1, 1'h1, 4'h1, 8'h00, a);
      check("async_extra", 32'(a - s1), 32'h1);
      if (ah == 0) s0 = s1;
    end
    check("polarity_len", 32'(s1), 32'(s0));
  endtask : t_modes
  task automatic t_stretch;
    int a, b;
    ready_async <= 1'b0;
    run(1'h1, 1'h1, 4'h1, 8'h08, a);
    run(1'h1, 1'h1, 4'h1, 8'h0B, b);
    check("ready_stretch", 32'(b - a), 32'h3);
  endtask : t_stretch
  // Reset between cycles must clear a held read word; clock output checked mid-phase
  task automatic t_reset;
    @(posedge clock);
    rst_n <= 1'h0;
    repeat (2) @(posedge clock);
    check("reset_busy", {31'h0, stat.busy}, 32'h0);
    check("reset_data", {16'h0000, read_data}, 32'h0);
    check("reset_valid", {31'h0, read_data_valid}, 32'h0);
    rst_n <= 1'h1;
    repeat (3) @(posedge clock);
    #2;
    check("ref_clock_hi", {31'h0, ref_clock}, 32'h1);
    #4;
    check("ref_clock_lo", {31'h0, ref_clock}, 32'h0);
  endtask : t_reset
  task automatic results;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    rst_n = 1'b0;
    req = '0;
    ready_active_high = 1'b1;
    ready_async = 1'b0;
    delay = 8'h00;
    word = 16'hA5C3;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_phases;
    t_modes;
    t_stretch;
    t_reset;
    results;
  end
  initial begin
    #20000;
    bad_count++;
    results;
  end
endmodule : external_bus_ready_wait_control_bench

// File: verilog/ebrwc_ctrl.sv
// Purpose: Wait-state and completion control for external bus cycles.
// Assumes: Requests from on-chip logic are synchronous to clock.
// Notes: reference_clock_output mirrors the bus clock.
// Operation
// - Read data captured on the edge that ends the read strobe.
// - Address changes at or after strobe end cannot disturb captured data.
// - Ready input may stretch any ready-controlled cycle; device holds it open.
// - Ready active level is selectable high or low.
// - Synchronous ready gives the shortest cycle, partner syncs to clock output.
// - Asynchronous ready adds a synchronising stage, at least one wait state.
// - First sample point follows the programmed phases of the cycle.
// - Inactive ready at sample point inserts one wait state, samples again.
// - Active ready at sample point completes the cycle.
// - Sync and async modes sample at the same points; async mode reads a ready level one stage later.
// - Mandatory wait states finish before ready is evaluated.
`timescale 1ns/1ps
`include "ebrwc_regs.svh"
module ebrwc_ctrl
  import ebrwc_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input ebrwc_req_t req,
  input wire logic ready_active_high,
  input wire logic ready_async,
  input wire logic ready_pin,
  input wire logic [DATA_W-1:0] data_pin,
  output ebrwc_stat_t stat,
  output logic [DATA_W-1:0] read_data,
  output logic read_data_valid,
  output logic reference_clock_output
);
  // A start seen while busy is dropped without any indication
  typedef enum logic [1:0] {ST_IDLE, ST_MAND, ST_RDY} ebrwc_state_t;
  ebrwc_state_t state;
  ebrwc_state_t next_state;
  logic rst_q1;
  logic rst_sync_n;
  logic [`EBRWC_PHASE_W-1:0] wait_cnt;
  logic [`EBRWC_PHASE_W-1:0] next_wait_cnt;
  logic cyc_read;
  logic cyc_rdyctl;
  logic rdy_sync;
  logic rdy_async;

  // Every flop but rst_q1 leaves reset on the same edge, two stages after the pin
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_q1 <= 1'h0;
      rst_sync_n <= 1'h0;
    end else begin
      rst_q1 <= 1'h1;
      rst_sync_n <= rst_q1;
    end
  end

  // Polarity and both synchroniser depths live in the conditioning block
  ebrwc_ready_sync u_sync (
    .clock(clock),
    .rst_sync_n(rst_sync_n),
    .ready_pin(ready_pin),
    .active_high(ready_active_high),
    .ready_sync_mode(rdy_sync),
    .ready_async_mode(rdy_async)
  );

  wire logic rdy_sel = ready_async ? rdy_async : rdy_sync;
  wire logic mand_done = (wait_cnt == `EBRWC_CNT_ZERO);
  // Sample point: after programmed mandatory phases; non-ready cycles end there
  wire logic sample_pt = (state == ST_RDY) || ((state == ST_MAND) && mand_done);
  wire logic cyc_end = sample_pt && (!cyc_rdyctl || rdy_sel);
  wire logic insert_wait = sample_pt && cyc_rdyctl && !rdy_sel;
  wire logic capture = cyc_end && cyc_read;

  // Counter loads on the taking edge and counts the mandatory phases down
  always_comb begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    unique case (state)
      ST_IDLE: begin
        if (req.start) begin
          next_state = ST_MAND;
          next_wait_cnt = req.mandatory_wait_phase;
        end
      end
      ST_MAND: begin
        if (!mand_done) begin
          next_wait_cnt = wait_cnt - `EBRWC_CNT_ONE;
        end else if (cyc_end) begin
          next_state = ST_IDLE;
        end else begin
          next_state = ST_RDY;
        end
      end
      ST_RDY: begin
        if (cyc_end) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // Cycle kind is latched when taken, so the request may move on at once
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= ST_IDLE;
      wait_cnt <= `EBRWC_CNT_ZERO;
      cyc_read <= 1'h0;
      cyc_rdyctl <= 1'h0;
    end else begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
      if (state == ST_IDLE && req.start) begin
        cyc_read <= req.is_read;
        cyc_rdyctl <= req.ready_ctrl;
      end
    end
  end

  // Data is taken on the strobe-ending edge, so late address moves do not matter
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      read_data <= '0;
      read_data_valid <= 1'h0;
    end else begin
      read_data_valid <= capture;
      if (capture) begin
        read_data <= data_pin;
      end
    end
  end

  // Strobe spans the whole cycle; the partner keys ready and data off it
  assign stat.busy = (state != ST_IDLE);
  assign stat.strobe = (state != ST_IDLE);
  assign stat.done = cyc_end;
  assign stat.ready_waitstate_phase = (state == ST_RDY);
  assign reference_clock_output = clock;

  property end_on_ready_p;
    @(posedge clock) disable iff (!rst_sync_n)
      (state == ST_RDY && cyc_rdyctl && rdy_sel) |-> stat.done ##1 (state == ST_IDLE);
  endproperty
  ready_ends_cycle_a: assert property (end_on_ready_p) else $error("cycle not ended on ready");
  hold_not_ready_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (sample_pt && cyc_rdyctl && !rdy_sel) |=> (state == ST_RDY))
    else $error("wait state not inserted");
  mand_before_ready_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (state == ST_MAND && !mand_done) |-> !stat.done)
    else $error("cycle ended during mandatory wait");
  sequence start_s;
    state == ST_IDLE && req.start;
  endsequence
  mand_count_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (start_s ##0 (req.mandatory_wait_phase == `EBRWC_CNT_ONE)) |=> !stat.done ##1 sample_pt)
    else $error("first sample point misplaced");
  read_capture_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (cyc_end && cyc_read) |=> (read_data_valid && read_data == $past(data_pin)))
    else $error("read data not captured at strobe end");
  async_extra_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    $rose(rdy_sync) |=> rdy_async)
    else $error("async stage not one cycle behind");
  sync_shortest_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (sample_pt && cyc_rdyctl && !ready_async && rdy_sync) |-> stat.done)
    else $error("sync ready did not end cycle");
  strobe_busy_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    stat.done |-> stat.strobe)
    else $error("done outside cycle");
  // Steps of a cycle: a refused sample, then the close-out
  sequence not_ready_s;
    sample_pt && cyc_rdyctl && !rdy_sel;
  endsequence
  sequence close_s;
    stat.done ##1 (state == ST_IDLE);
  endsequence
  start_taken_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    start_s |=> (stat.busy && state == ST_MAND))
    else $error("request not taken in idle");
  wait_resample_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    not_ready_s |=> (stat.ready_waitstate_phase && sample_pt))
    else $error("ready not sampled again after wait state");
  ready_closes_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (sample_pt && cyc_rdyctl && rdy_sel) |-> close_s)
    else $error("active ready did not close cycle");
  plain_closes_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (sample_pt && !cyc_rdyctl) |-> close_s)
    else $error("plain cycle not closed at sample point");
  done_pulse_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    stat.done |=> !stat.done)
    else $error("done longer than one cycle");
  idle_quiet_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (state == ST_IDLE) |-> (!stat.busy && !stat.done))
    else $error("idle shows cycle activity");
  busy_holds_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (stat.busy && !stat.done) |=> stat.busy)
    else $error("cycle dropped before done");
  wait_phase_ctl_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    stat.ready_waitstate_phase |-> (stat.busy && cyc_rdyctl))
    else $error("wait phase outside ready cycle");
  plain_no_wait_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (stat.busy && !cyc_rdyctl) |-> !stat.ready_waitstate_phase)
    else $error("plain cycle entered ready wait");
  async_lag_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (stat.done && cyc_rdyctl && ready_async) |-> $past(rdy_sync))
    else $error("async cycle ended without synced ready");
  mand_countdown_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (state == ST_MAND && !mand_done) |=> (wait_cnt == $past(wait_cnt) - `EBRWC_CNT_ONE))
    else $error("mandatory phase count skipped");
  valid_pulse_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    read_data_valid |=> !read_data_valid)
    else $error("read valid longer than one cycle");
  write_no_capture_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
    (stat.done && !cyc_read) |=> !read_data_valid)
    else $error("write cycle captured read data");
endmodule : ebrwc_ctrl

// File: verilog/ebrwc_pkg.sv
// Purpose: Types shared by the ready/wait control block.
// Assumes: Phase widths come from ebrwc_regs.svh.
// Notes: Cycle request and status travel as packed structs.
`include "ebrwc_regs.svh"
package ebrwc_pkg;
  typedef struct packed {
    logic start;
    logic is_read;
    logic ready_ctrl;
    logic [`EBRWC_PHASE_W-1:0] mandatory_wait_phase;
  } ebrwc_req_t;
  typedef struct packed {
    logic busy;
    logic strobe;
    logic done;
    logic ready_waitstate_phase;
  } ebrwc_stat_t;
endpackage : ebrwc_pkg

// File: verilog/ebrwc_ready_sync.sv
// Purpose: Ready input conditioning: polarity, pin capture, async synchroniser.
// Assumes: ready_pin is asynchronous to clock.
// Notes: Outputs a synchronous-mode and an asynchronous-mode ready level.
`timescale 1ns/1ps
module ebrwc_ready_sync (
  input wire logic clock,
  input wire logic rst_sync_n,
  input wire logic ready_pin,
  input wire logic active_high,
  output logic ready_sync_mode,
  output logic ready_async_mode
);
  logic pin_q1;
  logic pin_q2;
  logic pin_q3;
  logic extra_q;
  // Polarity applied before any flop so both modes see an active-high level
  wire logic ready_norm = active_high ? ready_pin : ~ready_pin;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_q1 <= 1'h0;
      pin_q2 <= 1'h0;
      pin_q3 <= 1'h0;
      extra_q <= 1'h0;
    end else begin
      pin_q1 <= ready_norm;
      pin_q2 <= pin_q1;
      pin_q3 <= pin_q2;
      extra_q <= (pin_q2 & pin_q3);
    end
  end
  // An active level counts once second and third stages agree
  assign ready_sync_mode = pin_q2 & pin_q3;
  // Extra stage costs one wait state but tolerates any input timing
  assign ready_async_mode = extra_q;
endmodule : ebrwc_ready_sync

// File: verilog/ebrwc_regs.svh
// Purpose: Constants for the external bus ready/wait control block.
// Assumes: Bus clock of 125 MHz (8 ns period).
// Notes: Phase counts are in bus clock cycles.
`ifndef EBRWC_REGS_SVH
`define EBRWC_REGS_SVH
`define EBRWC_CLK_PERIOD_PS 8000
`define EBRWC_PHASE_W 4
`define EBRWC_CNT_ZERO 4'h0
`define EBRWC_CNT_ONE 4'h1
`endif
